// ### hw/dpi_pkg.sv
// Package of constants for the dual potentiometer two-wire link.
// Assumes both ends are clocked by core_clk at 125 MHz.
package dpi_pkg;
  // Identification byte: upper four bits are the device-type code
  localparam logic [3:0] DPI_TYPE_CODE = 4'h5; // Value is arbitrary
  // Register space
  localparam logic [3:0] DPI_ADDR_LAST = 4'h8;
  localparam logic [3:0] DPI_ADDR_WIPER1 = 4'h1;
  localparam logic [3:0] DPI_ADDR_GP_LAST = 4'h6;
  localparam logic [3:0] DPI_ADDR_RSVD = 4'h7;
  localparam logic [3:0] DPI_ADDR_ACR = 4'h8;
  // Access control register fields and reset value
  localparam int DPI_ACR_VOL_BIT = 7;
  localparam int DPI_ACR_SHDN_BIT = 6;
  localparam int DPI_ACR_BUSY_BIT = 5;
  localparam logic [7:0] DPI_ACR_RESET = 8'h40;
  localparam logic [7:0] DPI_WIPER_RESET = 8'h40;
  localparam logic [7:0] DPI_NV_RESET = 8'h00;
  // Timing
  localparam int DPI_CLK_MHZ = 125;
  localparam int DPI_NV_WRITE_MS = 20;
  localparam int DPI_NV_WRITE_CYC = DPI_NV_WRITE_MS * 1000 * DPI_CLK_MHZ;
  localparam int DPI_POWERUP_CYC = 16;
  localparam int DPI_SCL_HALF_CYC = 8; // Quarter of a link clock, 64 ns
  localparam int DPI_CNT_W = 22;
endpackage : dpi_pkg

// ### hw/dpi_bus_if.sv
// Interface carrying the two open-drain wires between master and slave.
// Assumes external pull-ups: a line is low whenever any party drives it.
`timescale 1ns/10ps
interface dpi_bus_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open-drain wired-AND, pulled high when nobody drives
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_oe, input scl, input sda);
endinterface : dpi_bus_if

// ### hw/dpi_line_sync.sv
// Two-flop synchroniser plus edge finder for the bus lines.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/10ps
module dpi_line_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Raw lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Cleaned lines and events
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; idle bus is high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
    end
  end

  // Third stage holds the previous clean value for edge finding
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl <= 1'b1;
      sda <= 1'b1;
    end else begin
      scl <= scl_meta[1];
      sda <= sda_meta[1];
    end
  end

  // Data edges while clock stays high are conditions, not data
  assign scl_rise = scl_meta[1] & ~scl;
  assign scl_fall = ~scl_meta[1] & scl;
  assign start_seen = scl & scl_meta[1] & sda & ~sda_meta[1];
  assign stop_seen = scl & scl_meta[1] & ~sda & sda_meta[1];
endmodule : dpi_line_sync

// ### hw/dpi_slave.sv
// Device end: two-wire slave and register file of the dual potentiometer.
// Assumes a master on the other modport; core_clk at 125 MHz.
`timescale 1ns/10ps
// Operation
// - Device is slave only; master clocks
// - Bytes shift most significant bit first
// - Data changes only while clock low
// - Data pin released after power-up
// - Falling data, clock high means START
// - START ignored while powering up
// - STOP returns device to standby
// - Transmitter releases; receiver acks ninth clock
// - Ack identification, address, write data
// - Master acks each wanted read byte
// - Identification matches type code and pins
// - Identification low bit selects direction
// - Write is START, id, address, data, STOP
// - Write address wraps from 08h to 00h
// - Non-volatile write starts at STOP, 20ms
// - Read uses dummy write then repeated START
// - Transmit while master keeps acknowledging
// - Read pointer wraps from 08h to 00h
// - Host checks busy flag before readback
// - Map: pairs, general storage, reserved, control
// - Volatile select steers addresses 0 and 1
// - Busy flag blocks wiper, initial, control writes
module dpi_slave
  import dpi_pkg::*;
#(
  parameter int NV_WRITE_CYC = dpi_pkg::DPI_NV_WRITE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus
  dpi_bus_if.slave bus,
  // Address select pins
  input wire logic addr_select_pin_high,
  input wire logic addr_select_pin_mid,
  input wire logic addr_select_pin_low,
  // Wiper positions and status
  output logic [6:0] wiper0,
  output logic [6:0] wiper1,
  output logic shutdown_n,
  output logic nv_write_busy_flag
);
  import dpi_pkg::*;

  typedef enum logic [5:0] {
    DPI_IDLE = 6'h01, DPI_ID = 6'h02, DPI_ADDR = 6'h04,
    DPI_WDATA = 6'h08, DPI_RDATA = 6'h10, DPI_IGNORE = 6'h20
  } dpi_state_e;

  dpi_state_e state;
  logic scl, sda, scl_rise, scl_fall, start_seen, stop_seen;
  logic [2:0] pin_meta, pin_sync;
  logic [4:0] pwr_cnt;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [3:0] ptr;
  logic reading;
  logic nv_pending;
  logic [DPI_CNT_W-1:0] nv_cnt;
  logic [7:0] wiper [0:1];
  logic [7:0] initial_value_register [0:1];
  logic [7:0] gp [2:6];
  logic [7:0] access_control_register;
  logic [7:0] tx_byte;
  logic id_match;
  logic ack_phase;

  // Wrap past the last location back to zero
  function automatic logic [3:0] dpi_next_addr(input logic [3:0] a);
    dpi_next_addr = (a == DPI_ADDR_LAST) ? 4'h0 : 4'(a + 4'h1);
  endfunction : dpi_next_addr

  dpi_line_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .scl_in(bus.scl),
    .sda_in(bus.sda),
    .scl(scl),
    .sda(sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address pins are asynchronous straps: two flops before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {addr_select_pin_high, addr_select_pin_mid,
                   addr_select_pin_low};
      pin_sync <= pin_meta;
    end
  end

  // Power-up window; a START during it is dropped
  always_ff @(posedge core_clk) begin
    if (rst)
      pwr_cnt <= 5'h00;
    else if (pwr_cnt != 5'(DPI_POWERUP_CYC))
      pwr_cnt <= 5'(pwr_cnt + 5'h01);
  end

  assign id_match = (shreg[7:4] == DPI_TYPE_CODE) &&
                    (shreg[3:1] == pin_sync);
  assign ack_phase = (bit_cnt == 4'h9); // Ninth clock up; its fall ends byte

  // Data presented on reads; reserved location reads as zero
  always_comb begin
    tx_byte = 8'h00;
    if (ptr <= DPI_ADDR_WIPER1)
      tx_byte = access_control_register[DPI_ACR_VOL_BIT] ? wiper[ptr[0]] : initial_value_register[ptr[0]];
    else if (ptr <= DPI_ADDR_GP_LAST)
      tx_byte = gp[ptr[2:0]];
    else if (ptr == DPI_ADDR_ACR)
      tx_byte = {access_control_register[7:6], nv_pending, 5'h00};
  end

  ////////////////////////////////////////////////////////////////////////
  // Protocol state machine: bytes move at clock edges set by the master
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= DPI_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      reading <= 1'b0;
    end else if (start_seen && pwr_cnt == 5'(DPI_POWERUP_CYC)) begin
      state <= DPI_ID;
      bit_cnt <= 4'h0;
      reading <= 1'b0;
    end else if (stop_seen) begin
      state <= DPI_IDLE;
    end else begin
      case (state)
        DPI_IDLE, DPI_IGNORE: begin
          bit_cnt <= 4'h0;
        end
        DPI_ID, DPI_ADDR, DPI_WDATA, DPI_RDATA: begin
          if (scl_rise && bit_cnt < 4'h8) begin
            // Receive side samples on rising clock, MSB first
            shreg <= {shreg[6:0], sda};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end else if (scl_rise && bit_cnt == 4'h8) begin
            // Ninth clock: the acknowledge slot, byte stays intact
            bit_cnt <= 4'h9;
            if (state == DPI_RDATA)
              reading <= sda; // High means master declined more
          end else if (scl_fall && ack_phase) begin
            bit_cnt <= 4'h0;
            case (state)
              DPI_ID: begin
                if (!id_match)
                  state <= DPI_IGNORE;
                else if (shreg[0])
                  state <= DPI_RDATA;
                else
                  state <= DPI_ADDR;
              end
              DPI_ADDR: state <= DPI_WDATA;
              DPI_RDATA: state <= reading ? DPI_IGNORE : DPI_RDATA;
              default: state <= state;
            endcase
          end
        end
        default: state <= DPI_IDLE;
      endcase
    end
  end

  // Pointer loads from the address byte, steps per byte moved.
  // Reads step at the ack slot so the next byte is ready at its end.
  always_ff @(posedge core_clk) begin
    if (rst)
      ptr <= 4'h0;
    else if (scl_fall && ack_phase && state == DPI_ADDR)
      ptr <= (shreg > {4'h0, DPI_ADDR_LAST}) ? 4'h0 : shreg[3:0];
    else if (scl_fall && ack_phase && state == DPI_WDATA)
      ptr <= dpi_next_addr(ptr);
    else if (scl_fall && bit_cnt == 4'h8 && state == DPI_RDATA)
      ptr <= dpi_next_addr(ptr);
  end

  // Register writes at the end of each data byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wiper[0] <= DPI_WIPER_RESET;
      wiper[1] <= DPI_WIPER_RESET;
      initial_value_register[0] <= DPI_NV_RESET;
      initial_value_register[1] <= DPI_NV_RESET;
      for (int i = 2; i <= 6; i++)
        gp[i] <= DPI_NV_RESET;
      access_control_register <= DPI_ACR_RESET;
    end else if (scl_fall && ack_phase && state == DPI_WDATA) begin
      if (ptr <= DPI_ADDR_WIPER1 && !nv_pending) begin
        wiper[ptr[0]] <= {1'b0, shreg[6:0]};
        if (!access_control_register[DPI_ACR_VOL_BIT])
          initial_value_register[ptr[0]] <= {1'b0, shreg[6:0]};
      end else if (ptr > DPI_ADDR_WIPER1 && ptr <= DPI_ADDR_GP_LAST) begin
        gp[ptr[2:0]] <= shreg;
      end else if (ptr == DPI_ADDR_ACR && !nv_pending) begin
        access_control_register <= {shreg[7:6], 6'h00};
      end
    end
  end

  // Any non-volatile byte written while no cycle runs arms a cycle that starts at STOP
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nv_pending <= 1'b0;
      nv_cnt <= '0;
    end else if (nv_cnt != '0) begin
      nv_cnt <= DPI_CNT_W'(nv_cnt - 1'b1);
      nv_pending <= (nv_cnt != DPI_CNT_W'(1));
    end else if (stop_seen && nv_pending) begin
      nv_cnt <= DPI_CNT_W'(NV_WRITE_CYC);
    end else if (scl_fall && ack_phase && state == DPI_WDATA &&
                 ptr != DPI_ADDR_RSVD && ptr != DPI_ADDR_ACR &&
                 (ptr > DPI_ADDR_WIPER1 || !access_control_register[DPI_ACR_VOL_BIT])) begin
      nv_pending <= 1'b1;
    end
  end

  // Open-drain data drive changes after a falling clock edge; START or STOP releases it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus.sda_s_oe <= 1'b0;
    end else if (start_seen || stop_seen) begin
      bus.sda_s_oe <= 1'b0;
    end else if (scl_fall) begin
      bus.sda_s_oe <= 1'b0;
      if (bit_cnt == 4'h8 && (state == DPI_ADDR || state == DPI_WDATA ||
          (state == DPI_ID && id_match)))
        bus.sda_s_oe <= 1'b1;
      else if (state == DPI_RDATA && bit_cnt != 4'h0 && bit_cnt < 4'h8)
        bus.sda_s_oe <= ~tx_byte[3'(4'h7 - bit_cnt)];
      else if (ack_phase && !reading && (state == DPI_RDATA ||
               (state == DPI_ID && id_match && shreg[0])))
        bus.sda_s_oe <= ~tx_byte[7];
    end
  end

  // Outputs from flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wiper0 <= 7'h40;
      wiper1 <= 7'h40;
      shutdown_n <= 1'b1;
      nv_write_busy_flag <= 1'b0;
    end else begin
      wiper0 <= wiper[0][6:0];
      wiper1 <= wiper[1][6:0];
      shutdown_n <= access_control_register[DPI_ACR_SHDN_BIT];
      nv_write_busy_flag <= nv_pending;
    end
  end
endmodule : dpi_slave

// ### hw/dpi_master.sv
// Other end: simple two-wire master that runs one write or one read.
// Assumes the slave on the other modport; clock made by a divider here.
`timescale 1ns/10ps
module dpi_master
  import dpi_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus
  dpi_bus_if.master bus,
  // Request: go pulses, read selects direction
  input wire logic go,
  input wire logic read,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] count,
  // Answer
  output logic busy,
  output logic rvalid,
  output logic [7:0] rdata,
  output logic nack
);
  import dpi_pkg::*;

  typedef enum logic [3:0] {
    DPM_IDLE = 4'h1, DPM_START = 4'h2, DPM_BIT = 4'h4, DPM_STOP = 4'h8
  } dpm_state_e;

  dpm_state_e state;
  logic [3:0] ph_cnt;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  logic [2:0] byte_no;
  logic [3:0] left;
  logic rd_op, rd_phase;
  logic [1:0] sda_s;
  logic tick;

  assign tick = (ph_cnt == 4'(DPI_SCL_HALF_CYC - 1));

  // Sample the shared data line through two flops
  always_ff @(posedge core_clk) begin
    if (rst)
      sda_s <= 2'h3;
    else
      sda_s <= {sda_s[0], bus.sda};
  end

  // Divider makes the link clock in quarter phases
  always_ff @(posedge core_clk) begin
    if (rst || state == DPM_IDLE)
      ph_cnt <= 4'h0;
    else
      ph_cnt <= tick ? 4'h0 : 4'(ph_cnt + 4'h1);
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: id, address, then data or repeated START and reads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= DPM_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      byte_no <= 3'h0;
      left <= 4'h0;
      rd_op <= 1'b0;
      rd_phase <= 1'b0;
      bus.scl_m_oe <= 1'b0;
      bus.sda_m_oe <= 1'b0;
      busy <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 8'h00;
      nack <= 1'b0;
    end else begin
      rvalid <= 1'b0;
      case (state)
        DPM_IDLE: begin
          if (go) begin
            state <= DPM_START;
            phase <= 2'h0;
            busy <= 1'b1;
            nack <= 1'b0;
            rd_op <= read;
            rd_phase <= 1'b0;
            left <= (count == 4'h0) ? 4'h1 : count;
            byte_no <= 3'h0;
            sh <= {dev_addr, 1'b0};
          end
        end
        DPM_START: if (tick) begin
          // Data falls while clock high, then clock falls
          phase <= 2'(phase + 2'h1);
          case (phase)
            2'h0: begin
              bus.sda_m_oe <= 1'b0;
              bus.scl_m_oe <= 1'b0;
            end
            2'h1: bus.sda_m_oe <= 1'b1;
            default: begin
              bus.scl_m_oe <= 1'b1;
              state <= DPM_BIT;
              bit_cnt <= 4'h0;
              phase <= 2'h0;
            end
          endcase
        end
        DPM_BIT: if (tick) begin
          phase <= 2'(phase + 2'h1);
          case (phase)
            2'h0: begin
              // Set data during clock low, MSB first
              if (bit_cnt == 4'h8)
                bus.sda_m_oe <= rd_phase && left != 4'h1;
              else
                bus.sda_m_oe <= rd_phase ? 1'b0 : ~sh[7];
            end
            2'h1: bus.scl_m_oe <= 1'b0;
            2'h2: begin
              if (bit_cnt == 4'h8) begin
                if (!rd_phase && sda_s[1])
                  nack <= 1'b1;
              end else begin
                sh <= {sh[6:0], sda_s[1]};
              end
            end
            default: begin
              bus.scl_m_oe <= 1'b1;
              if (bit_cnt != 4'h8) begin
                bit_cnt <= 4'(bit_cnt + 4'h1);
              end else begin
                bit_cnt <= 4'h0;
                byte_no <= 3'(byte_no + 3'h1);
                if (rd_phase) begin
                  rvalid <= 1'b1;
                  rdata <= sh;
                  left <= 4'(left - 4'h1);
                  if (left == 4'h1)
                    state <= DPM_STOP;
                end else if (nack) begin
                  state <= DPM_STOP;
                end else if (byte_no == 3'h0) begin
                  sh <= reg_addr;
                end else if (byte_no == 3'h1 && rd_op) begin
                  sh <= {dev_addr, 1'b1};
                  bus.sda_m_oe <= 1'b0;
                  state <= DPM_START;
                end else if (byte_no == 3'h1) begin
                  sh <= wdata;
                end else if (rd_op) begin
                  // Read identification taken: data bytes follow
                  rd_phase <= 1'b1;
                end else begin
                  state <= DPM_STOP;
                end
              end
            end
          endcase
        end
        DPM_STOP: if (tick) begin
          // Data rises while clock high
          phase <= 2'(phase + 2'h1);
          case (phase)
            2'h0: bus.sda_m_oe <= 1'b1;
            2'h1: bus.scl_m_oe <= 1'b0;
            2'h2: bus.sda_m_oe <= 1'b0;
            default: begin
              state <= DPM_IDLE;
              busy <= 1'b0;
            end
          endcase
        end
        default: state <= DPM_IDLE;
      endcase
    end
  end
endmodule : dpi_master

// ### testbench/dpi_link_assertions.sv
// Checker of the two-wire lines between the master and the slave end.
// Assumes the lines are sampled by core_clk; instantiated, not bound.
`timescale 1ns/10ps
module dpi_link_assertions #(
  parameter logic [6:0] ID7 = 7'h00
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Interface lines
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, seen_start, matched, nomatch, rd_mode;
  logic scl_rise, start_ev, stop_ev, ninth;
  logic [7:0] sh;
  logic [3:0] bitcnt;
  logic [3:0] bytes;
  ////////////////////////////////////////////////////////////////////
  // Line events; raw lines are already in the core_clk domain here
  assign scl_rise = scl && !scl_q;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;
  assign ninth = scl_rise && (bitcnt == 4'h8);
  // Previous line levels, released lines idle high
  always_ff @(posedge core_clk) begin
    scl_q <= rst ? 1'b1 : scl;
    sda_q <= rst ? 1'b1 : sda;
  end
  // Bit and byte position since the last START
  always_ff @(posedge core_clk) begin
    if (rst || start_ev) begin
      bitcnt <= 4'h0;
      bytes <= 4'h0;
    end else if (ninth) begin
      bitcnt <= 4'h0;
      bytes <= (bytes == 4'hF) ? bytes : bytes + 4'h1;
    end else if (scl_rise) begin
      bitcnt <= bitcnt + 4'h1;
      sh <= {sh[6:0], sda}; // First bit lands at the top
    end
  end
  // Frame state decoded from the identification byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seen_start <= 1'b0;
      matched <= 1'b0;
      nomatch <= 1'b0;
      rd_mode <= 1'b0;
    end else if (start_ev) begin
      seen_start <= 1'b1;
      matched <= 1'b0;
      nomatch <= 1'b0;
    end else if (ninth && bytes == 4'h0) begin
      matched <= (sh[7:1] == ID7);
      nomatch <= (sh[7:1] != ID7);
      rd_mode <= sh[0];
    end else if (stop_ev) begin
      matched <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_lines_free: assert property (disable iff (1'b0)
    rst |=> !sda_s_oe && !scl_m_oe && !sda_m_oe)
    else $error("lines driven after reset");
  a_slave_sda_steady: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave moved data while clock high");
  a_idle_before_start: assert property (
    !seen_start |-> !sda_s_oe)
    else $error("slave drove before any start");
  a_id_match_ack: assert property (
    ninth && bytes == 4'h0 && sh[7:1] == ID7 |-> sda_s_oe)
    else $error("valid identification not acknowledged");
  a_id_miss_noack: assert property (
    ninth && bytes == 4'h0 && sh[7:1] != ID7 |-> !sda_s_oe)
    else $error("foreign identification acknowledged");
  a_miss_stays_off: assert property (
    nomatch |-> !sda_s_oe)
    else $error("slave drove after foreign identification");
  a_write_byte_ack: assert property (
    ninth && matched && !rd_mode && bytes != 4'h0 |-> sda_s_oe && !sda_m_oe)
    else $error("written byte not acknowledged by slave");
  a_read_ack_free: assert property (
    ninth && matched && rd_mode && bytes != 4'h0 |-> !sda_s_oe)
    else $error("slave held data in acknowledge slot");
  a_stop_standby: assert property (
    stop_ev |=> (!sda_s_oe) [*8])
    else $error("slave drove after stop");
  // Main scenarios
  c_read_data: cover property (ninth && matched && rd_mode && bytes != 4'h0);
  c_write_data: cover property (ninth && matched && !rd_mode && bytes == 4'h2);
  c_foreign_id: cover property (ninth && bytes == 4'h0 && sh[7:1] != ID7);
  c_stop: cover property (stop_ev);
endmodule : dpi_link_assertions

// ### testbench/testbench.sv
// Self-checking bench joining the master end to the slave end.
// Assumes fixed address pins; a short non-volatile write time.
`timescale 1ns/10ps
module testbench;
  import dpi_pkg::*;
  localparam logic [2:0] PINS = 3'h5;
  localparam logic [6:0] ID7 = {DPI_TYPE_CODE, PINS};
  localparam int NV_CYC = 4000; // Long enough to read while busy
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic read = 1'b0;
  logic [6:0] dev_addr = 7'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [3:0] count = 4'h1;
  logic [2:0] pins = PINS;
  logic busy, rvalid, nack, shutdown_n, nv_write_busy_flag;
  logic [7:0] rdata;
  logic [6:0] wiper0, wiper1;
  logic [7:0] got [$];
  int n_fail = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////////////
  dpi_bus_if bus ();
  dpi_slave #(.NV_WRITE_CYC(NV_CYC)) dpi_slave_i (.core_clk(core_clk),
    .rst(rst), .bus(bus), .addr_select_pin_high(pins[2]),
    .addr_select_pin_mid(pins[1]), .addr_select_pin_low(pins[0]),
    .wiper0(wiper0), .wiper1(wiper1), .shutdown_n(shutdown_n),
    .nv_write_busy_flag(nv_write_busy_flag));
  dpi_master dpi_master_i (.core_clk(core_clk), .rst(rst), .bus(bus),
    .go(go), .read(read), .dev_addr(dev_addr), .reg_addr(reg_addr),
    .wdata(wdata), .count(count), .busy(busy), .rvalid(rvalid),
    .rdata(rdata), .nack(nack));
  dpi_link_assertions #(.ID7(ID7)) dpi_link_assertions_i (
    .core_clk(core_clk), .rst(rst), .scl_m_oe(bus.scl_m_oe),
    .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl),
    .sda(bus.sda));
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic exp, input logic seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk1
  // One request; inputs stay held until the next one
  task automatic xfer(input logic rd, input logic [6:0] dev,
                      input logic [7:0] ra, input logic [7:0] wd,
                      input logic [3:0] cnt);
    int n;
    got.delete();
    @(posedge core_clk);
    go <= 1'b1;
    read <= rd;
    dev_addr <= dev;
    reg_addr <= ra;
    wdata <= wd;
    count <= cnt;
    @(posedge core_clk);
    go <= 1'b0;
    for (n = 0; n < 20000; n++) begin
      @(negedge core_clk);
      if (rvalid === 1'b1) got.push_back(rdata);
      if (n > 2 && busy === 1'b0) break;
    end
    if (n == 20000) chk1("transfer end", 1'b0, 1'b1);
  endtask : xfer
  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    xfer(1'b0, ID7, ra, wd, 4'h1);
    chk1("write nack", 1'b0, nack);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ra, input logic [3:0] cnt,
                        input logic [7:0] exp [$]);
    xfer(1'b1, ID7, ra, 8'h00, cnt);
    chk8("read count", 8'(exp.size()), 8'(got.size()));
    foreach (exp[i]) begin
      chk8("read byte", exp[i], (i < got.size()) ? got[i] : 8'hXX);
    end
  endtask : rd_chk
  // Bounded wait for the non-volatile write to finish
  task automatic wait_nv;
    int n;
    for (n = 0; n < NV_CYC + 1000 && nv_write_busy_flag !== 1'b0; n++) begin
      @(negedge core_clk);
    end
    chk1("busy flag end", 1'b0, nv_write_busy_flag);
  endtask : wait_nv
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the expected run of about 26500 cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    $display("watchdog expired");
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (24) @(posedge core_clk); // Past the power-up window
    @(negedge core_clk);
    chk1("sda idle", 1'b1, bus.sda);
    chk8("wiper0 reset", DPI_WIPER_RESET, {1'b0, wiper0});
    chk1("shutdown reset", 1'b1, shutdown_n);
    rd_chk(8'h08, 4'h2, '{DPI_ACR_RESET, DPI_NV_RESET});
    $display("test reset done");
    // Each bit of the identification wrong in turn
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ID7 ^ (7'h01 << i), 8'h00, 8'h55, 4'h1);
      chk1("foreign id nack", 1'b1, nack);
    end
    chk8("wiper0 untouched", DPI_WIPER_RESET, {1'b0, wiper0});
    $display("test identification done");
    wr(8'h08, 8'hC0);
    wr(8'h00, 8'h12);
    chk8("wiper0 volatile", 8'h12, {1'b0, wiper0});
    chk1("no nv write", 1'b0, nv_write_busy_flag);
    rd_chk(8'h06, 4'h4, '{8'h00, 8'h00, 8'hC0, 8'h12});
    wr(8'h08, 8'h80);
    chk1("shutdown bit", 1'b0, shutdown_n);
    wr(8'h08, 8'hC0);
    $display("test volatile done");
    wr(8'h03, 8'hA5);
    chk1("busy after stop", 1'b1, nv_write_busy_flag);
    rd_chk(8'h08, 4'h1, '{8'hE0});
    wr(8'h01, 8'h2A);
    chk8("wiper1 blocked", DPI_WIPER_RESET, {1'b0, wiper1});
    wait_nv();
    rd_chk(8'h03, 4'h1, '{8'hA5});
    $display("test nonvolatile done");
    wr(8'h08, 8'h40);
    wr(8'h01, 8'h33);
    chk8("wiper1 follows", 8'h33, {1'b0, wiper1});
    chk1("initial busy", 1'b1, nv_write_busy_flag);
    wait_nv();
    wr(8'h07, 8'hFF);
    wait_nv();
    rd_chk(8'h00, 4'hA, '{8'h00, 8'h33, 8'h00, 8'hA5, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h40, 8'h00});
    $display("test wrap done");
    end_of_test();
  end
endmodule : testbench
